/* File: sim/fsif_macro_model.sv */
// stand-in for the flash macro status outputs
module fsif_macro_model (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // command from the bench: 1 program, 2 erase, 3 suspend, 4 chip, 5 fail, 6 reset
    input  wire logic [2:0]       cmd,
    // macro status levels
    output fsif_pkg::fsif_macro_t st
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    always_ff @(posedge clk)
    begin
        case (reset ? 3'h7 : cmd)
            3'h1: {st, cnt_r} <= {6'h20, 4'h8};
            3'h2: {st, cnt_r} <= {6'h10, 4'h8};
            3'h3: {st, cnt_r} <= {st | 6'h09, 4'h0};
            3'h4: {st, cnt_r} <= {6'h04, 4'h8};
            3'h5: {st, cnt_r} <= {6'h02, 4'h0};
            3'h6: {st, cnt_r} <= {6'h01, 4'h0};
            3'h7: {st, cnt_r} <= {6'h00, 4'h1};
            default:
            begin
                cnt_r <= cnt_r - {3'h0, cnt_r != 4'h0};
                if (cnt_r == 4'h1)
                    st <= 6'h01;
            end
        endcase
    end
endmodule // fsif_macro_model

/* File: sim/fsif_status_flags_assertions.sv */
// port checks of the flash status and flag block
module fsif_status_flags_assertions (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  reset,
    // register port
    input wire logic [3:0]            regAddr,
    input wire logic                  regWrite,
    input wire logic                  regRead,
    input wire logic                  regRmw,
    input wire logic [15:0]           regRdData,
    // macro and events
    input wire fsif_pkg::fsif_macro_t macroStatus,
    input wire fsif_pkg::fsif_event_t events,
    input wire logic [6:0]            flagIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic stRd;
    logic flRd;
    assign stRd = regRead && regAddr == fsif_pkg::ADDR_STATUS;
    assign flRd = regRead && regAddr == fsif_pkg::ADDR_FLAGS;

    AST_STATUS: assert property (
        stRd |=> regRdData[5:1] == $past(macroStatus[5:1], 2))
        else $error("status bits differ from macro");
    AST_READY: assert property (
        stRd |=> regRdData[0] == $past(macroStatus.ready && !macroStatus.hang, 2))
        else $error("ready bit wrong");
    AST_RMW: assert property (flRd && regRmw |=> regRdData[14:8] == 7'h7F)
        else $error("rmw read not all ones");
    AST_TOP_BIT: assert property (flRd |=> regRdData[15] == fsif_pkg::UNUSED_RD)
        else $error("top flag bit wrong");
    AST_ERR_CAUSE: assert property ($rose(flagIrq[6]) |->
        $past(events.seqWriteFail) || $past(regWrite) || $past(regWrite, 2))
        else $error("error request without cause");
    AST_ERR_KEEP: assert property (flagIrq[6] && !regWrite |=> flagIrq[6])
        else $error("error request dropped");
    AST_FIN_AUTO: assert property (
        events.autoFlagClear && !events.seqWriteDone |=> !flagIrq[5])
        else $error("finish request survives auto clear");
    AST_WPS_CAUSE: assert property ($rose(flagIrq[2]) |->
        $past(events.flashWrite && events.protectedHit) || $past(regWrite) || $past(regWrite, 2))
        else $error("protected request without cause");
    AST_HANG_EDGE: assert property ($rose(flagIrq[1]) |->
        ($past(macroStatus.hang) && !$past(macroStatus.hang, 2)) || $past(regWrite)
        || $past(regWrite, 2))
        else $error("hang request without rising hang");
    cover property (flRd && regRmw);
    cover property ($rose(flagIrq[6]));
    cover property (stRd && macroStatus.hang);
endmodule // fsif_status_flags_assertions

bind fsif_status_flags fsif_status_flags_assertions i_fsif_status_flags_assertions (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regRmw(regRmw), .regRdData(regRdData), .macroStatus(macroStatus), .events(events),
    .flagIrq(flagIrq)
);

/* File: sim/tb_fsif_status_flags.sv */
// self-checking bench of the flash status and flag block
module tb_fsif_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0;
    logic                  reset = 1'b1;
    logic [3:0]            regAddr = '0;
    logic [15:0]           regWrData = '0;
    logic                  regWrite = 1'b0;
    logic                  regRead = 1'b0;
    logic                  regRmw = 1'b0;
    logic [15:0]           regRdData;
    fsif_pkg::fsif_macro_t macroStatus;
    fsif_pkg::fsif_event_t events = '0;
    logic                  seqWriteEnable;
    logic [6:0]            flagIrq;
    logic [2:0]            cmd = '0;
    logic [15:0]           v;
    logic [15:0]           r;
    int                    mismatches = 0;
    int                    num_checks = 0;
    int                    seed = 51;
    logic [8:0]            evA [5] = '{9'h040, 9'h020, 9'h014, 9'h110, 9'h002};
    logic [8:0]            evB [5] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h010};
    logic [15:0]           evF [5] = '{16'h4000, 16'h2000, 16'h0400, 16'h1800, 16'h0800};
    logic [2:0]            cl [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
    always #12.5 clk = ~clk;
    fsif_status_flags i_fsif_status_flags (
        .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRmw(regRmw), .regRdData(regRdData),
        .macroStatus(macroStatus), .events(events), .seqWriteEnable(seqWriteEnable),
        .flagIrq(flagIrq)
    );
    fsif_macro_model i_fsif_macro_model (.clk(clk), .reset(reset), .cmd(cmd), .st(macroStatus));

    function automatic logic [15:0] exp_st(input logic [2:0] c);
        case (c)
            3'h1: return 16'h0020;
            3'h2: return 16'h0019;
            3'h4: return 16'h0004;
            default: return 16'h0002;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic m);
        @(posedge clk);
        regRead <= 1'b1;
        regRmw <= m;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        regRmw <= 1'b0;
        @(posedge clk);
        v = regRdData;
    endtask
    task automatic ev(input logic [8:0] e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        rd(fsif_pkg::ADDR_STATUS, 1'b0);
        chk(v, 16'h00C1);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h0100);
        wr(fsif_pkg::ADDR_FLAGS, 16'h7FFF);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h0100);
        wr(fsif_pkg::ADDR_FLAGS, 16'h0000);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h0000);
        rd(4'h7, 1'b0);
        chk(v, 16'h0000);
        wr(fsif_pkg::ADDR_IRQ_EN, 16'h7F00);
        wr(fsif_pkg::ADDR_CONFIG, 16'h0001);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h1000);
        chk({15'h0000, seqWriteEnable}, 16'h0001);
        $display("reset and access test done");
        for (int i = 0; i < 5; i++)
        begin
            wr(fsif_pkg::ADDR_FLAGS, 16'h0000);
            ev(evA[i]);
            ev(evB[i]);
            rd(fsif_pkg::ADDR_FLAGS, 1'b0);
            chk(v, evF[i]);
            chk({9'h000, flagIrq}, {9'h000, evF[i][14:8]});
        end
        wr(fsif_pkg::ADDR_FLAGS, 16'h0000);
        ev(9'h160);
        rd(fsif_pkg::ADDR_FLAGS, 1'b1);
        chk(v, 16'h7F00);
        ev(9'h001);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h4000);
        // write error cause found through the protected flag
        wr(fsif_pkg::ADDR_FLAGS, 16'h0000);
        ev(9'h054);
        rd(fsif_pkg::ADDR_FLAGS, 1'b0);
        chk(v, 16'h4400);
        events <= 9'h100;
        rd(fsif_pkg::ADDR_STATUS, 1'b0);
        chk(v, 16'h0041);
        events <= 9'h080;
        rd(fsif_pkg::ADDR_STATUS, 1'b0);
        chk(v, 16'h0081);
        events <= '0;
        $display("flag event test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(fsif_pkg::ADDR_FLAGS, 16'h0000);
            @(posedge clk);
            cmd <= cl[i];
            @(posedge clk);
            cmd <= (cl[i] == 3'h2) ? 3'h3 : 3'h0;
            @(posedge clk);
            cmd <= 3'h0;
            ev(9'h010);
            rd(fsif_pkg::ADDR_STATUS, 1'b0);
            chk(v, exp_st(cl[i]));
            rd(fsif_pkg::ADDR_FLAGS, 1'b0);
            chk(v, cl[i] == 3'h2 ? 16'h0100 : cl[i] == 3'h5 ? 16'h0200 : 16'h0800);
            @(posedge clk);
            cmd <= 3'h6;
            @(posedge clk);
            cmd <= 3'h0;
            repeat (10) @(posedge clk);
            rd(fsif_pkg::ADDR_STATUS, 1'b0);
            chk(v, 16'h0001);
        end
        $display("macro status test done");
        repeat (20)
        begin
            r = 16'($random(seed));
            wr(fsif_pkg::ADDR_STATUS, r);
            wr(fsif_pkg::ADDR_IRQ_EN, r & 16'h7F00);
            rd(fsif_pkg::ADDR_STATUS, 1'b0);
            chk(v, 16'h0001);
            rd(fsif_pkg::ADDR_IRQ_EN, 1'b0);
            chk(v, r & 16'h7F00);
        end
        $display("random register test done");
        print_verdict();
    end
endmodule // tb_fsif_status_flags

/* File: verilog/fsif_pkg.sv */
// package: register map, field positions and carriers of the flash status/flag block
package fsif_pkg;
    // register addresses (word index on the register port)
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_FLAGS   = 4'h1;
    localparam logic [3:0] ADDR_IRQ_EN  = 4'h2;
    localparam logic [3:0] ADDR_CONFIG  = 4'h3;
    // status register fields
    localparam int ST_RDY   = 0;
    localparam int ST_HANG  = 1;
    localparam int ST_CHIP  = 2;
    localparam int ST_SUSP  = 3;
    localparam int ST_SECT  = 4;
    localparam int ST_PGM   = 5;
    localparam int ST_SEQLO = 6;
    localparam int ST_SEQHI = 7;
    // flag / enable fields (16-bit register, low byte reads zero)
    localparam int FL_RDY   = 8;
    localparam int FL_HANG  = 9;
    localparam int FL_WPS   = 10;
    localparam int FL_WB    = 11;
    localparam int FL_IDLE  = 12;
    localparam int FL_FIN   = 13;
    localparam int FL_ERR   = 14;
    localparam int FL_UNUSED = 15;
    // config register field
    localparam int CFG_SEQ_WE = 0;
    // reset values
    localparam logic [15:0] FLAGS_RST  = 16'h0000;
    localparam logic [15:0] IRQEN_RST  = 16'h0000;
    localparam logic        SEQ_WE_RST = 1'b0;
    // value returned for the undefined top flag bit
    localparam logic        UNUSED_RD  = 1'b0;

    // sequencer state encoding
    typedef enum logic [1:0] {
        FSIF_SEQ_IDLE = 2'b00,
        FSIF_SEQ_SEND = 2'b01,
        FSIF_SEQ_POLL = 2'b10,
        FSIF_SEQ_OFF  = 2'b11
    } fsif_seq_t;

    // flash macro status outputs
    typedef struct packed {
        logic programActive;
        logic sectorEraseActive;
        logic eraseSuspendAccepted;
        logic chipEraseActive;
        logic hang;
        logic ready;
    } fsif_macro_t;

    // sequencer and access events from the surrounding interface
    typedef struct packed {
        logic seqActive;      // sequencer is writing a word
        logic seqPolling;     // sequencer waits for end of programming
        logic seqWriteFail;   // sequencer could not write the data
        logic seqWriteDone;   // sequencer finished a write successfully
        logic flashWrite;     // a write command is presented to the flash
        logic writeIsSusRes;  // that write is suspend/resume/sector-add
        logic protectedHit;   // that write targets a protected sector
        logic standbyExit;    // first access after leaving standby
        logic autoFlagClear;  // auto transfer clears finish/idle flags
    } fsif_event_t;
endpackage

/* File: verilog/fsif_status_flags.sv */
// flash operation status and sticky interrupt flags with register port
//
// The plain strobed port and the register offsets were left to the implementer.
module fsif_status_flags (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // register port
    input  wire logic [3:0]           regAddr,
    input  wire logic [15:0]          regWrData,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    input  wire logic                 regRmw,
    output logic [15:0]               regRdData,
    // flash macro status and interface events
    input  wire fsif_pkg::fsif_macro_t macroStatus,
    input  wire fsif_pkg::fsif_event_t events,
    // sequencer write enable and flag requests
    output logic                      seqWriteEnable,
    output logic [6:0]                flagIrq
);
    // each instance keeps its own state; no shared storage
    fsif_pkg::fsif_macro_t  macro_r;
    fsif_pkg::fsif_seq_t    seqState_r;
    fsif_pkg::fsif_seq_t    seqState_nxt;
    logic [15:0]            flags_r;
    logic [15:0]            flags_nxt;
    logic [15:0]            irqEn_r;
    logic                   seqWe_r;
    logic                   busyDet;
    logic                   busyDet_r;
    logic                   protDet_r;
    logic                   standbyPend_r;
    logic [15:0]            setMask;
    logic [15:0]            clrMask;
    logic [7:0]             statusVal;
    logic                   wrFlags;
    logic                   wrCfg;

    assign wrFlags = regWrite && (regAddr == fsif_pkg::ADDR_FLAGS);
    assign wrCfg   = regWrite && (regAddr == fsif_pkg::ADDR_CONFIG);

    // macro status captured once per clock; no register write reaches it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            macro_r <= '0;
        end
        else
        begin
            macro_r <= macroStatus;
        end
    end

    // sequencer enable
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            seqWe_r <= fsif_pkg::SEQ_WE_RST;
        end
        else if (wrCfg)
        begin
            seqWe_r <= regWrData[fsif_pkg::CFG_SEQ_WE];
        end
    end

    // sequencer state view
    always_comb
    begin
        if (!seqWe_r)
        begin
            seqState_nxt = fsif_pkg::FSIF_SEQ_OFF;
        end
        else if (events.seqPolling)
        begin
            seqState_nxt = fsif_pkg::FSIF_SEQ_POLL;
        end
        else if (events.seqActive)
        begin
            seqState_nxt = fsif_pkg::FSIF_SEQ_SEND;
        end
        else
        begin
            seqState_nxt = fsif_pkg::FSIF_SEQ_IDLE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            seqState_r <= fsif_pkg::FSIF_SEQ_OFF;
        end
        else
        begin
            seqState_r <= seqState_nxt;
        end
    end

    // busy detection for write commands the flash cannot take
    always_comb
    begin
        busyDet = 1'b0;
        if (events.flashWrite && !macro_r.hang && !macro_r.eraseSuspendAccepted)
        begin
            if (events.seqActive || events.seqPolling)
            begin
                busyDet = 1'b1;
            end
            else if (macro_r.programActive || macro_r.chipEraseActive)
            begin
                busyDet = 1'b1;
            end
            else if (macro_r.sectorEraseActive && !events.writeIsSusRes)
            begin
                busyDet = 1'b1;
            end
            else if (standbyPend_r)
            begin
                busyDet = 1'b1;
            end
        end
    end

    // pending marker for the first write after standby exit
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            standbyPend_r <= 1'b0;
        end
        else if (events.standbyExit)
        begin
            standbyPend_r <= 1'b1;
        end
        else if (events.flashWrite)
        begin
            standbyPend_r <= 1'b0;
        end
    end

    // edge detector history
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            busyDet_r <= 1'b0;
            protDet_r <= 1'b0;
        end
        else
        begin
            busyDet_r <= busyDet;
            protDet_r <= events.flashWrite && events.protectedHit;
        end
    end

    // flag set and clear masks; set wins over clear
    always_comb
    begin
        setMask = '0;
        setMask[fsif_pkg::FL_ERR]  = events.seqWriteFail;
        setMask[fsif_pkg::FL_FIN]  = events.seqWriteDone;
        setMask[fsif_pkg::FL_IDLE] = (seqState_nxt == fsif_pkg::FSIF_SEQ_IDLE)
                                     && (seqState_r != fsif_pkg::FSIF_SEQ_IDLE);
        setMask[fsif_pkg::FL_WB]   = busyDet && !busyDet_r;
        setMask[fsif_pkg::FL_WPS]  = events.flashWrite && events.protectedHit
                                     && !protDet_r;
        setMask[fsif_pkg::FL_HANG] = macroStatus.hang && !macro_r.hang;
        setMask[fsif_pkg::FL_RDY]  = macroStatus.ready && !macro_r.ready
                                     && !macroStatus.hang;
        clrMask = '0;
        if (wrFlags)
        begin
            clrMask[14:8] = ~regWrData[14:8];
        end
        if (events.autoFlagClear)
        begin
            clrMask[fsif_pkg::FL_FIN]  = 1'b1;
            clrMask[fsif_pkg::FL_IDLE] = 1'b1;
        end
        flags_nxt = (flags_r & ~clrMask) | setMask;
        flags_nxt[fsif_pkg::FL_UNUSED] = 1'b0;
        flags_nxt[7:0] = '0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_r <= fsif_pkg::FLAGS_RST;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // interrupt enables
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irqEn_r <= fsif_pkg::IRQEN_RST;
        end
        else if (regWrite && (regAddr == fsif_pkg::ADDR_IRQ_EN))
        begin
            irqEn_r <= {1'b0, regWrData[14:8], 8'h00};
        end
    end

    // gated requests, one per flag
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flagIrq <= '0;
        end
        else
        begin
            flagIrq <= flags_nxt[14:8] & irqEn_r[14:8];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            seqWriteEnable <= 1'b0;
        end
        else
        begin
            seqWriteEnable <= seqWe_r;
        end
    end

    // status view; ready forced low under hang
    always_comb
    begin
        statusVal = '0;
        statusVal[fsif_pkg::ST_RDY]   = macro_r.ready && !macro_r.hang;
        statusVal[fsif_pkg::ST_HANG]  = macro_r.hang;
        statusVal[fsif_pkg::ST_CHIP]  = macro_r.chipEraseActive;
        statusVal[fsif_pkg::ST_SUSP]  = macro_r.eraseSuspendAccepted;
        statusVal[fsif_pkg::ST_SECT]  = macro_r.sectorEraseActive;
        statusVal[fsif_pkg::ST_PGM]   = macro_r.programActive;
        statusVal[fsif_pkg::ST_SEQLO] = seqState_r[0];
        statusVal[fsif_pkg::ST_SEQHI] = seqState_r[1];
    end

    // read data, valid the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            regRdData <= '0;
        end
        else if (regRead)
        begin
            if (regAddr == fsif_pkg::ADDR_STATUS)
            begin
                regRdData <= {8'h00, statusVal};
            end
            else if (regAddr == fsif_pkg::ADDR_FLAGS)
            begin
                if (regRmw)
                begin
                    regRdData <= {fsif_pkg::UNUSED_RD, 7'h7f, 8'h00};
                end
                else
                begin
                    regRdData <= {fsif_pkg::UNUSED_RD, flags_r[14:0]};
                end
            end
            else if (regAddr == fsif_pkg::ADDR_IRQ_EN)
            begin
                regRdData <= irqEn_r;
            end
            else if (regAddr == fsif_pkg::ADDR_CONFIG)
            begin
                regRdData <= {15'h0000, seqWe_r};
            end
            else
            begin
                regRdData <= '0;
            end
        end
        else
        begin
            regRdData <= '0;
        end
    end
endmodule // fsif_status_flags
